// [verilog/cbiu_pkg.sv]
package cbiu_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_DIV = CLK_HZ / BAUD_DEFAULT;
  localparam logic [15:0] BAUD_RELOAD_RST = 16'(32'h0001_0000 - BAUD_DIV);

  localparam logic [31:0] MEM_BASE = 32'h0000_0000;
  localparam int MEM_AW = 11;
  localparam int MEM_WORDS = 2048;
  localparam logic [31:0] SERIAL_DATA_ADDR = 32'h7000_0000;
  localparam logic [31:0] SERIAL_BAUD_ADDR = 32'h7000_0001;
  localparam logic [31:0] SERIAL_CLR_ADDR = 32'h7000_0002;
  localparam logic [31:0] TICK_RELOAD_ADDR = 32'h7000_0020;
  localparam logic [31:0] TICK_CTRL_ADDR = 32'h7000_0021;
  localparam logic [31:0] NIBBLE_ADDR = 32'h7000_0030;
  localparam logic [31:0] ANALOG_ADDR = 32'h7000_0040;

  localparam int TX_EMPTY_BIT = 8;
  localparam int RX_FULL_BIT = 9;
  localparam int TICK_FLAG_RD_BIT = 0;
  localparam int TICK_FLAG_WR_BIT = 1;
  localparam int TICK_EN_BIT = 0;

  localparam logic [15:0] TICK_RELOAD_RST = 16'h0000;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [10:0] PWM_RST = 11'h000;
  localparam int TX_FRAME_BITS = 11;
  localparam logic [3:0] RX_STOP_IDX = 4'h9;
  localparam int TXQ_DEPTH = 2;

  typedef enum logic [1:0] {PH_LOW_LATCH, PH_LOW_HOLD, PH_HIGH} cbiu_phase_t;
  typedef enum logic {SER_IDLE, SER_BUSY} cbiu_ser_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
  } cbiu_cpu_req_t;

endpackage : cbiu_pkg

// [verilog/cbiu_bus_glue_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module cbiu_bus_glue_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // cpu side
  input wire cbiu_pkg::cbiu_cpu_req_t cpuReq,
  output logic [15:0] cpuDataIn,
  output logic coreClock,
  output logic cpuResetN,
  output logic busWait,
  output logic fastInterruptRequest,
  // serial pins
  input wire logic serialRx,
  output logic serialTx,
  // output port and analog
  output logic [3:0] outputNibble,
  input wire logic sigmaCompare,
  output logic sigmaFeedback,
  output logic pwmOut
);
  cbiu_pkg::cbiu_phase_t phase_r;
  logic coreClock_r;
  logic cpuResetN_r;
  logic busWait_r;
  logic [15:0] cpuDataIn_r;
  // ---------------- clock divider and bus phase machine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_r <= cbiu_pkg::PH_LOW_LATCH;
      coreClock_r <= 1'b0;
    end else begin
      unique case (phase_r)
        cbiu_pkg::PH_LOW_LATCH: begin
          phase_r <= cbiu_pkg::PH_LOW_HOLD;
          coreClock_r <= 1'b0;
        end
        cbiu_pkg::PH_LOW_HOLD: begin
          phase_r <= cbiu_pkg::PH_HIGH;
          coreClock_r <= 1'b1;
        end
        cbiu_pkg::PH_HIGH: begin
          phase_r <= cbiu_pkg::PH_LOW_LATCH;
          coreClock_r <= 1'b0;
        end
      endcase
    end
  end
  // cpu leaves reset on a phase boundary so its first edge is a clean one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpuResetN_r <= 1'b0;
    end else if (phase_r == cbiu_pkg::PH_LOW_LATCH) begin
      cpuResetN_r <= 1'b1;
    end
  end
  // ---------------- decode
  logic latchPhase;
  logic wrStrobe;
  logic txStall;
  logic doWrite;
  logic txInReady;
  logic [15:0] rdData;
  assign latchPhase = (phase_r == cbiu_pkg::PH_LOW_LATCH) && cpuResetN_r;
  assign wrStrobe = latchPhase && cpuReq.wr;
  assign txStall = wrStrobe && (cpuReq.addr == cbiu_pkg::SERIAL_DATA_ADDR) && !txInReady;
  assign doWrite = wrStrobe && !txStall;
  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a == b);
  endfunction : hit
  // a full transmit buffer stretches the write instead of dropping the byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busWait_r <= 1'b0;
    end else if (latchPhase) begin
      busWait_r <= txStall;
    end
  end
  // ---------------- system memory
  logic [15:0] memArray [cbiu_pkg::MEM_WORDS];
  logic [15:0] memQ;
  logic memHit;
  assign memHit = (cpuReq.addr[31:cbiu_pkg::MEM_AW] ==
                   cbiu_pkg::MEM_BASE[31:cbiu_pkg::MEM_AW]);
  // array has no reset; a boot image is preloaded by the build flow
  always_ff @(posedge core_clk) begin
    if (doWrite && memHit) begin
      memArray[cpuReq.addr[cbiu_pkg::MEM_AW-1:0]] <= cpuReq.wdata;
    end
    memQ <= memArray[cpuReq.addr[cbiu_pkg::MEM_AW-1:0]];
  end
  // ---------------- serial port registers
  logic [15:0] baudReload_r;
  logic rxFull_r;
  logic [7:0] rxData_r;
  logic rxDone;
  logic [7:0] rxShift_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      baudReload_r <= cbiu_pkg::BAUD_RELOAD_RST;
    end else if (doWrite && hit(cpuReq.addr, cbiu_pkg::SERIAL_BAUD_ADDR)) begin
      baudReload_r <= cpuReq.wdata;
    end
  end
  // a frame finishing in the clearing cycle keeps the flag set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxFull_r <= 1'b0;
      rxData_r <= 8'h00;
    end else if (rxDone) begin
      rxFull_r <= 1'b1;
      rxData_r <= rxShift_r;
    end else if (doWrite && hit(cpuReq.addr, cbiu_pkg::SERIAL_CLR_ADDR)) begin
      rxFull_r <= 1'b0;
    end
  end
  // ---------------- transmit buffer, two entries
  logic [7:0] txqMem [cbiu_pkg::TXQ_DEPTH];
  logic txqWrPtr_r;
  logic txqRdPtr_r;
  logic [1:0] txqCount_r;
  logic txqPush;
  logic txqPop;
  logic txqValid;
  assign txInReady = (txqCount_r != 2'(cbiu_pkg::TXQ_DEPTH));
  assign txqValid = (txqCount_r != 2'h0);
  assign txqPush = doWrite && hit(cpuReq.addr, cbiu_pkg::SERIAL_DATA_ADDR);
  genvar e;
  generate
    for (e = 0; e < cbiu_pkg::TXQ_DEPTH; e++) begin : gTxq
      always_ff @(posedge core_clk) begin
        if (txqPush && (txqWrPtr_r == 1'(e))) begin
          txqMem[e] <= cpuReq.wdata[7:0];
        end
      end
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txqWrPtr_r <= 1'b0;
      txqRdPtr_r <= 1'b0;
      txqCount_r <= 2'h0;
    end else begin
      if (txqPush) begin
        txqWrPtr_r <= ~txqWrPtr_r;
      end
      if (txqPop) begin
        txqRdPtr_r <= ~txqRdPtr_r;
      end
      txqCount_r <= txqCount_r + 2'(txqPush) - 2'(txqPop);
    end
  end
  // ---------------- transmitter, 8 data bits and two stop bits
  cbiu_pkg::cbiu_ser_t txState_r;
  logic [15:0] txBaud_r;
  logic [10:0] txShift_r;
  logic [3:0] txBits_r;
  logic txTick;
  logic serialTx_r;
  assign txTick = (txBaud_r == 16'hFFFF);
  assign txqPop = (txState_r == cbiu_pkg::SER_IDLE) && txqValid;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txState_r <= cbiu_pkg::SER_IDLE;
      txBaud_r <= cbiu_pkg::BAUD_RELOAD_RST;
      txShift_r <= 11'h7FF;
      txBits_r <= 4'h0;
      serialTx_r <= 1'b1;
    end else begin
      unique case (txState_r)
        cbiu_pkg::SER_IDLE: begin
          serialTx_r <= 1'b1;
          if (txqValid) begin
            txShift_r <= {2'b11, txqMem[txqRdPtr_r], 1'b0};
            txBits_r <= 4'h0;
            txBaud_r <= baudReload_r;
            txState_r <= cbiu_pkg::SER_BUSY;
          end
        end
        cbiu_pkg::SER_BUSY: begin
          serialTx_r <= txShift_r[0];
          if (txTick) begin
            txBaud_r <= baudReload_r;
            txShift_r <= {1'b1, txShift_r[10:1]};
            txBits_r <= txBits_r + 4'h1;
            if (txBits_r == 4'(cbiu_pkg::TX_FRAME_BITS - 1)) begin
              txState_r <= cbiu_pkg::SER_IDLE;
            end
          end else begin
            txBaud_r <= txBaud_r + 16'h0001;
          end
        end
      endcase
    end
  end
  // ---------------- receiver, samples mid-bit
  logic rxMeta_r;
  logic rxSync_r;
  cbiu_pkg::cbiu_ser_t rxState_r;
  logic [15:0] rxBaud_r;
  logic [3:0] rxIdx_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      rxMeta_r <= serialRx;
      rxSync_r <= rxMeta_r;
    end
  end
  assign rxDone = (rxState_r == cbiu_pkg::SER_BUSY) && (rxBaud_r == 16'hFFFF) &&
                  (rxIdx_r == cbiu_pkg::RX_STOP_IDX) && rxSync_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxState_r <= cbiu_pkg::SER_IDLE;
      rxBaud_r <= 16'h0000;
      rxIdx_r <= 4'h0;
      rxShift_r <= 8'h00;
    end else begin
      unique case (rxState_r)
        cbiu_pkg::SER_IDLE: begin
          if (!rxSync_r) begin
            // half a bit first, so every later sample lands mid-bit
            rxBaud_r <= baudReload_r + {1'b0, ~baudReload_r[15:1]};
            rxIdx_r <= 4'h0;
            rxState_r <= cbiu_pkg::SER_BUSY;
          end
        end
        cbiu_pkg::SER_BUSY: begin
          if (rxBaud_r == 16'hFFFF) begin
            rxBaud_r <= baudReload_r;
            rxIdx_r <= rxIdx_r + 4'h1;
            if (rxIdx_r == 4'h0 && rxSync_r) begin
              rxState_r <= cbiu_pkg::SER_IDLE;
            end else if (rxIdx_r == cbiu_pkg::RX_STOP_IDX) begin
              rxState_r <= cbiu_pkg::SER_IDLE;
            end else if (rxIdx_r != 4'h0) begin
              rxShift_r <= {rxSync_r, rxShift_r[7:1]};
            end
          end else begin
            rxBaud_r <= rxBaud_r + 16'h0001;
          end
        end
      endcase
    end
  end
  // ---------------- system timer, advances once per cpu clock
  logic [15:0] tickReload_r;
  logic [15:0] tickCount_r;
  logic tickEnable_r;
  logic tickFlag_r;
  logic tickStep;
  logic tickOverflow;
  logic ctrlWrite;
  assign tickStep = (phase_r == cbiu_pkg::PH_HIGH) && tickEnable_r;
  assign tickOverflow = tickStep && (tickCount_r == 16'hFFFF);
  assign ctrlWrite = doWrite && hit(cpuReq.addr, cbiu_pkg::TICK_CTRL_ADDR);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickReload_r <= cbiu_pkg::TICK_RELOAD_RST;
    end else if (doWrite && hit(cpuReq.addr, cbiu_pkg::TICK_RELOAD_ADDR)) begin
      tickReload_r <= cpuReq.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickCount_r <= cbiu_pkg::TICK_RELOAD_RST;
    end else if (tickOverflow) begin
      tickCount_r <= tickReload_r;
    end else if (tickStep) begin
      tickCount_r <= tickCount_r + 16'h0001;
    end
  end
  // an overflow in the writing cycle wins over a write of zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickEnable_r <= 1'b0;
      tickFlag_r <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        tickEnable_r <= cpuReq.wdata[cbiu_pkg::TICK_EN_BIT];
      end
      if (tickOverflow) begin
        tickFlag_r <= 1'b1;
      end else if (ctrlWrite) begin
        tickFlag_r <= cpuReq.wdata[cbiu_pkg::TICK_FLAG_WR_BIT];
      end
    end
  end
  // ---------------- output nibble, rate multiplier, converter
  logic [3:0] outputNibble_r;
  logic [10:0] pwmValue_r;
  logic [10:0] pwmAcc_r;
  logic pwmOut_r;
  logic analogWrite;
  assign analogWrite = doWrite && hit(cpuReq.addr, cbiu_pkg::ANALOG_ADDR);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outputNibble_r <= cbiu_pkg::NIBBLE_RST;
    end else if (doWrite && hit(cpuReq.addr, cbiu_pkg::NIBBLE_ADDR)) begin
      outputNibble_r <= cpuReq.wdata[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwmValue_r <= cbiu_pkg::PWM_RST;
    end else if (analogWrite) begin
      pwmValue_r <= cpuReq.wdata[10:0];
    end
  end

  // carry of the accumulator spreads value/2048 pulses evenly
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwmAcc_r <= 11'h000;
      pwmOut_r <= 1'b0;
    end else begin
      {pwmOut_r, pwmAcc_r} <= {1'b0, pwmAcc_r} + {1'b0, pwmValue_r};
    end
  end
  logic cmpMeta_r;
  logic cmpSync_r;
  logic sigmaFeedback_r;
  logic [10:0] adcWindow_r;
  logic [11:0] adcOnes_r;
  logic [10:0] adcSample_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmpMeta_r <= 1'b0;
      cmpSync_r <= 1'b0;
      sigmaFeedback_r <= 1'b0;
    end else begin
      cmpMeta_r <= sigmaCompare;
      cmpSync_r <= cmpMeta_r;
      sigmaFeedback_r <= cmpSync_r;
    end
  end

  // ones counted over a 2048-cycle window; a full window saturates
  always_ff @(posedge core_clk) begin
    if (rst) begin
      adcWindow_r <= 11'h000;
      adcOnes_r <= 12'h000;
      adcSample_r <= 11'h000;
    end else begin
      adcWindow_r <= adcWindow_r + 11'h001;
      if (adcWindow_r == 11'h7FF) begin
        adcSample_r <= adcOnes_r[11] ? 11'h7FF : adcOnes_r[10:0];
        adcOnes_r <= {11'h000, sigmaFeedback_r};
      end else begin
        adcOnes_r <= adcOnes_r + {11'h000, sigmaFeedback_r};
      end
    end
  end

  // ---------------- read mux and cpu data latch
  always_comb begin
    rdData = 16'h0000;
    if (memHit) begin
      rdData = memQ;
    end else if (hit(cpuReq.addr, cbiu_pkg::SERIAL_DATA_ADDR)) begin
      rdData[7:0] = rxData_r;
      rdData[cbiu_pkg::TX_EMPTY_BIT] = txInReady;
      rdData[cbiu_pkg::RX_FULL_BIT] = rxFull_r;
    end else if (hit(cpuReq.addr, cbiu_pkg::TICK_CTRL_ADDR)) begin
      rdData[cbiu_pkg::TICK_FLAG_RD_BIT] = tickFlag_r;
    end else if (hit(cpuReq.addr, cbiu_pkg::ANALOG_ADDR)) begin
      rdData[10:0] = adcSample_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpuDataIn_r <= 16'h0000;
    end else if (latchPhase && cpuReq.rd) begin
      cpuDataIn_r <= rdData;
    end
  end

  // ---------------- outputs, all straight from flip-flops
  assign cpuDataIn = cpuDataIn_r;
  assign coreClock = coreClock_r;
  assign cpuResetN = cpuResetN_r;
  assign busWait = busWait_r;
  assign fastInterruptRequest = tickFlag_r;
  assign serialTx = serialTx_r;
  assign outputNibble = outputNibble_r;
  assign sigmaFeedback = sigmaFeedback_r;
  assign pwmOut = pwmOut_r;

endmodule : cbiu_bus_glue_unit
`default_nettype wire

// [verification/cbiu_bus_glue_unit_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cbiu_bus_glue_unit_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // cpu side
  input wire cbiu_pkg::cbiu_cpu_req_t cpuReq,
  input wire logic [15:0] cpuDataIn,
  input wire logic coreClock,
  input wire logic cpuResetN,
  input wire logic busWait,
  input wire logic fastInterruptRequest,
  // pins
  input wire logic serialRx,
  input wire logic serialTx,
  input wire logic [3:0] outputNibble,
  input wire logic sigmaCompare,
  input wire logic sigmaFeedback,
  input wire logic pwmOut
);
  logic prevHigh_r;
  logic latchPh;
  logic rdEv;
  logic wrEv;
  logic zeroRd;
  logic [3:0] wdLo;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prevHigh_r <= 1'b0;
    end else begin
      prevHigh_r <= coreClock;
    end
  end
  // requests are taken at the edge closing the cycle after the high phase
  assign latchPh = prevHigh_r && cpuResetN;
  assign rdEv = latchPh && cpuReq.rd;
  assign wrEv = latchPh && cpuReq.wr;
  assign zeroRd = rdEv && (cpuReq.addr inside {32'h7000_0001, 32'h7000_0002,
                                                32'h7000_0020, 32'h7000_0030});
  assign wdLo = cpuReq.wdata[3:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_clock_third: assert property (coreClock |=> !coreClock ##1 !coreClock ##1 coreClock)
    else $error("cpu clock ratio wrong");
  a_clock_gap: assert property (!coreClock ##1 !coreClock |=> coreClock)
    else $error("cpu clock low too long");
  a_reset_release: assert property ($fell(rst) |=> cpuResetN)
    else $error("cpu reset not released");
  a_reset_steady: assert property (cpuResetN |=> cpuResetN)
    else $error("cpu reset glitch");
  a_nibble_write: assert property (wrEv && cpuReq.addr == 32'h7000_0030
    |=> outputNibble == $past(wdLo))
    else $error("output port not loaded");
  a_nibble_cause: assert property (!$stable(outputNibble) |-> $past(wrEv))
    else $error("output port changed without write");
  a_read_zero: assert property (zeroRd |=> cpuDataIn == 16'h0000)
    else $error("write-only read not zero");
  a_data_cause: assert property (!$stable(cpuDataIn) |-> $past(rdEv))
    else $error("read data changed outside latch");
  a_flag_set: assert property (wrEv && cpuReq.addr == 32'h7000_0021 && cpuReq.wdata[1]
    |=> fastInterruptRequest)
    else $error("overflow flag not set");
  a_wait_cause: assert property ($rose(busWait) |-> $past(wrEv))
    else $error("wait without write");
  a_wait_edge: assert property (!$stable(busWait) |-> $past(latchPh))
    else $error("wait moved outside latch");
  a_feedback_sync: assert property ($stable(sigmaCompare) [*4]
    |-> sigmaFeedback == sigmaCompare)
    else $error("feedback not following comparator");
endmodule : cbiu_bus_glue_unit_monitor

bind cbiu_bus_glue_unit cbiu_bus_glue_unit_monitor u_monitor (
  .core_clk(core_clk), .rst(rst), .cpuReq(cpuReq), .cpuDataIn(cpuDataIn),
  .coreClock(coreClock), .cpuResetN(cpuResetN), .busWait(busWait),
  .fastInterruptRequest(fastInterruptRequest), .serialRx(serialRx), .serialTx(serialTx),
  .outputNibble(outputNibble), .sigmaCompare(sigmaCompare),
  .sigmaFeedback(sigmaFeedback), .pwmOut(pwmOut)
);
`default_nettype wire

// [verification/cbiu_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cbiu_cpu_model (
  // clock
  input wire logic core_clk,
  // unit side
  input wire logic coreClock,
  input wire logic cpuResetN,
  input wire logic busWait,
  input wire logic [15:0] cpuDataIn,
  output var cbiu_pkg::cbiu_cpu_req_t cpuReq,
  // cpu cycles spent frozen
  output var int stalls
);
  int ph = 0;
  initial begin
    cpuReq = '0;
    stalls = 0;
  end
  always @(posedge core_clk) begin
    ph <= coreClock ? 0 : ph + 1;
  end
  // the request goes out as the cpu clock rises and holds through the latch;
  // a raised wait freezes it for whole cpu cycles
  task automatic access(input logic wr, input logic [31:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    int n;
    n = 0;
    do @(posedge core_clk); while (ph != 1 || cpuResetN !== 1'b1);
    cpuReq <= '{a, d, ~wr, wr};
    do begin
      repeat (3) @(posedge core_clk);
      n++;
    end while (busWait === 1'b1 && n < 2000);
    stalls = stalls + n - 1;
    q = cpuDataIn;
    // a released bus does not keep its last value
    cpuReq <= '{~a, ~d, 1'b0, 1'b0};
  endtask : access
  // an immediate load of three words: opcode, two operands, then the opcode
  // again, on four cpu cycles in a row with no idle cycle between them
  task automatic fetch_long(input logic [31:0] pc, output logic [63:0] w);
    do @(posedge core_clk); while (ph != 1 || cpuResetN !== 1'b1);
    for (int i = 0; i < 4; i++) begin
      cpuReq <= '{pc + 32'(i % 3), 16'h0000, 1'b1, 1'b0};
      repeat (3) @(posedge core_clk);
      w[16*i +: 16] = cpuDataIn;
    end
    cpuReq <= '{~pc, 16'hFFFF, 1'b0, 1'b0};
  endtask : fetch_long
  // a single-word store: opcode fetch, the store itself, and no refetch after
  task automatic fetch_store(input logic [31:0] pc, input logic [31:0] a,
                             input logic [15:0] d, output logic [15:0] op);
    do @(posedge core_clk); while (ph != 1 || cpuResetN !== 1'b1);
    cpuReq <= '{pc, 16'h0000, 1'b1, 1'b0};
    repeat (3) @(posedge core_clk);
    op = cpuDataIn;
    cpuReq <= '{a, d, 1'b0, 1'b1};
    repeat (3) @(posedge core_clk);
    cpuReq <= '{~a, ~d, 1'b0, 1'b0};
  endtask : fetch_store
endmodule : cbiu_cpu_model
`default_nettype wire

// [verification/cbiu_bus_glue_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cbiu_bus_glue_unit_tb;
  logic core_clk;
  logic rst;
  cbiu_pkg::cbiu_cpu_req_t cpuReq;
  logic [15:0] cpuDataIn;
  logic coreClock;
  logic cpuResetN;
  logic busWait;
  logic fastInterruptRequest;
  logic serialRx;
  logic serialTx;
  logic [3:0] outputNibble;
  logic sigmaCompare;
  logic sigmaFeedback;
  logic pwmOut;
  logic loopOn;
  int stalls;
  int errors = 0;
  int samples_checked = 0;

  cbiu_bus_glue_unit dut (
    .core_clk(core_clk), .rst(rst), .cpuReq(cpuReq), .cpuDataIn(cpuDataIn),
    .coreClock(coreClock), .cpuResetN(cpuResetN), .busWait(busWait),
    .fastInterruptRequest(fastInterruptRequest), .serialRx(serialRx), .serialTx(serialTx),
    .outputNibble(outputNibble), .sigmaCompare(sigmaCompare),
    .sigmaFeedback(sigmaFeedback), .pwmOut(pwmOut)
  );
  cbiu_cpu_model cpu (
    .core_clk(core_clk), .coreClock(coreClock), .cpuResetN(cpuResetN), .busWait(busWait),
    .cpuDataIn(cpuDataIn), .cpuReq(cpuReq), .stalls(stalls)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // the far end of the serial line echoes our own output
  always @(posedge core_clk) begin
    serialRx <= loopOn ? serialTx : 1'b1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [15:0] x;
    cpu.access(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    cpu.access(1'b0, a, 16'h0000, d);
  endtask : rd

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic t_reset;
    int n;
    n = 0;
    repeat (20) @(posedge core_clk);
    chk({7'h00, cpuResetN, coreClock, busWait, serialTx, fastInterruptRequest, outputNibble},
        16'h0020);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({15'h0000, cpuResetN}, 16'h0001);
    repeat (30) begin
      @(posedge core_clk);
      n += coreClock;
    end
    chk(16'(n), 16'h000A);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_memory;
    logic [15:0] q;
    logic [31:0] al [3];
    al = '{32'h0000_0000, 32'h0000_0001, 32'h0000_07FF};
    foreach (al[i]) wr(al[i], 16'hA5A0 ^ 16'(i));
    wr(32'h0000_0800, 16'h1111);
    foreach (al[i]) begin
      rd(al[i], q);
      chk(q, 16'hA5A0 ^ 16'(i));
    end
    rd(32'h0000_0800, q);
    chk(q, 16'h0000);
    $display("t_memory done");
  endtask : t_memory

  // back-to-back cpu cycles out of memory, as instructions run them
  task automatic t_fetch;
    logic [15:0] q;
    logic [63:0] w;
    wr(32'h0000_0010, 16'hB130);
    wr(32'h0000_0011, 16'h0000);
    wr(32'h0000_0012, 16'h0100);
    cpu.fetch_long(32'h0000_0010, w);
    chk(w[15:0], 16'hB130);
    chk(w[31:16], 16'h0000);
    chk(w[47:32], 16'h0100);
    chk(w[63:48], 16'hB130);
    wr(32'h0000_0014, 16'hE120);
    cpu.fetch_store(32'h0000_0014, 32'h0000_0020, 16'h1234, q);
    chk(q, 16'hE120);
    rd(32'h0000_0020, q);
    chk(q, 16'h1234);
    $display("t_fetch done");
  endtask : t_fetch

  task automatic t_ports;
    logic [15:0] q;
    logic [31:0] al [6];
    al = '{32'h7000_0001, 32'h7000_0002, 32'h7000_0020, 32'h7000_0030, 32'h7000_0031,
           32'h6FFF_FFFF};
    wr(cbiu_pkg::NIBBLE_ADDR, 16'hFFF6);
    chk({12'h000, outputNibble}, 16'h0006);
    wr(32'h7000_0031, 16'h0009);
    chk({12'h000, outputNibble}, 16'h0006);
    foreach (al[i]) begin
      rd(al[i], q);
      chk(q, 16'h0000);
    end
    $display("t_ports done");
  endtask : t_ports

  task automatic t_timer;
    logic [15:0] q;
    wr(cbiu_pkg::TICK_RELOAD_ADDR, 16'hFFF0);
    wr(cbiu_pkg::TICK_CTRL_ADDR, 16'h0002);
    chk({15'h0000, fastInterruptRequest}, 16'h0001);
    rd(cbiu_pkg::TICK_CTRL_ADDR, q);
    chk({15'h0000, q[0]}, 16'h0001);
    wr(cbiu_pkg::TICK_CTRL_ADDR, 16'hFFFC);
    chk({15'h0000, fastInterruptRequest}, 16'h0000);
    rd(cbiu_pkg::TICK_CTRL_ADDR, q);
    chk({15'h0000, q[0]}, 16'h0000);
    $display("t_timer done");
  endtask : t_timer

  task automatic t_serial;
    logic [15:0] q;
    logic [10:0] f;
    int s;
    s = stalls;
    loopOn <= 1'b1;
    fork
      begin
        for (int k = 0; k < 200 && serialTx !== 1'b0; k++) @(posedge core_clk);
        repeat (cbiu_pkg::BAUD_DIV / 2) @(posedge core_clk);
        for (int k = 0; k < 11; k++) begin
          f[k] = serialTx;
          repeat (cbiu_pkg::BAUD_DIV) @(posedge core_clk);
        end
        chk({5'h00, f}, {5'h00, 2'b11, 8'h5A, 1'b0});
      end
      begin
        wr(cbiu_pkg::SERIAL_DATA_ADDR, 16'hFF5A);
        wr(cbiu_pkg::SERIAL_DATA_ADDR, 16'h00C3);
        wr(cbiu_pkg::SERIAL_DATA_ADDR, 16'h000F);
        wr(cbiu_pkg::SERIAL_DATA_ADDR, 16'h00F0);
        rd(cbiu_pkg::SERIAL_DATA_ADDR, q);
        chk(q & 16'h0100, 16'h0000);
      end
    join
    chk({15'h0000, 1'(stalls > s)}, 16'h0001);
    repeat (8000) @(posedge core_clk);
    rd(cbiu_pkg::SERIAL_DATA_ADDR, q);
    chk(q & 16'h03FF, 16'h03F0);
    wr(cbiu_pkg::SERIAL_CLR_ADDR, 16'h1234);
    rd(cbiu_pkg::SERIAL_DATA_ADDR, q);
    chk(q & 16'h0200, 16'h0000);
    wr(cbiu_pkg::SERIAL_BAUD_ADDR, 16'hFFD8);
    wr(cbiu_pkg::SERIAL_DATA_ADDR, 16'h0096);
    repeat (600) @(posedge core_clk);
    rd(cbiu_pkg::SERIAL_DATA_ADDR, q);
    chk(q & 16'h03FF, 16'h0396);
    loopOn <= 1'b0;
    $display("t_serial done");
  endtask : t_serial

  task automatic t_analog;
    logic [15:0] q;
    int n;
    n = 0;
    sigmaCompare <= 1'b1;
    repeat (4200) @(posedge core_clk);
    rd(cbiu_pkg::ANALOG_ADDR, q);
    chk(q & 16'h07FF, 16'h07FF);
    sigmaCompare <= 1'b0;
    repeat (4200) @(posedge core_clk);
    rd(cbiu_pkg::ANALOG_ADDR, q);
    chk(q & 16'h07FF, 16'h0000);
    wr(cbiu_pkg::ANALOG_ADDR, 16'hF200);
    repeat (2048) begin
      @(posedge core_clk);
      n += pwmOut;
    end
    chk(16'(n), 16'h0200);
    $display("t_analog done");
  endtask : t_analog

  initial begin
    rst = 1'b1;
    serialRx = 1'b1;
    sigmaCompare = 1'b0;
    loopOn = 1'b0;
    t_reset();
    t_memory();
    t_fetch();
    t_ports();
    t_timer();
    t_serial();
    t_analog();
    close_out();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    close_out();
  end
endmodule : cbiu_bus_glue_unit_tb
`default_nettype wire
